// File: nv_access_pkg.sv
// constants and types for the nonvolatile byte access unit
// Function
// [RULE_01] 64-byte array reached only through side registers
// [RULE_02] core keeps address bit 6 at zero
// [RULE_03] data register holds write byte or read byte
// [RULE_04] address register moves to and from accumulator
// [RULE_05] data register moves to and from accumulator
// [RULE_06] array read loads data register, accumulator undefined
// [RULE_07] array write programs data byte when unlocked
// [RULE_08] core writes three key codes in order
// [RULE_09] full key sequence lifts write protection
// [RULE_10] key register is write-only, loaded by instruction
// [RULE_11] finished write sets flag, interrupt if enabled
// [RULE_12] array write captures time-out code from accumulator
// [RULE_13] time-out 1/2/4/8 ms or 4/8/16/32 ms by scale
// [RULE_14] software sets time-out code before writing
// [RULE_15] software should enable watchdog or time-out
// [RULE_16] time-out error flag when write overruns, else zero
// [RULE_17] lock status reads one while locked, resets one
// [RULE_18] protection returns after write ends or times out
package nv_access_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned BASE_MS       = 1;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * BASE_MS;
  localparam int unsigned ARRAY_BYTES   = 64;
  localparam int unsigned ADDR_W        = 7;
  localparam logic [7:0]  KEY_FIRST     = 8'hC9;
  localparam logic [7:0]  KEY_SECOND    = 8'h3A;
  localparam logic [7:0]  KEY_THIRD     = 8'hD3;
  localparam logic [1:0]  KEY_STAGE_0   = 2'h0;
  localparam logic [1:0]  KEY_STAGE_1   = 2'h1;
  localparam logic [1:0]  KEY_STAGE_2   = 2'h2;
  localparam logic [1:0]  KEY_STAGE_OK  = 2'h3;
  localparam logic [5:0]  SCALE_FINE_SH = 6'h00;
  localparam logic [5:0]  SCALE_COARSE_SH = 6'h02;
  localparam int unsigned PROG_CYCLES_DEF = 2000;

  typedef enum logic [2:0] {
    INSTR_NONE,
    INSTR_ADDR_READ,
    INSTR_ADDR_WRITE,
    INSTR_DATA_READ,
    INSTR_DATA_WRITE,
    INSTR_ARRAY_READ,
    INSTR_ARRAY_WRITE,
    INSTR_KEY_WRITE
  } instr_type;

  typedef enum logic {
    ST_IDLE,
    ST_PROG
  } state_type;
endpackage : nv_access_pkg

// File: eeprom_access_unit.sv
// instruction-driven access unit for the 64-byte nonvolatile data array
`timescale 1ns/1ps
module eeprom_access_unit #(
  parameter int unsigned PROG_CYCLES = nv_access_pkg::PROG_CYCLES_DEF,
  parameter int unsigned MS_CYCLES   = nv_access_pkg::MS_CYCLES
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  input  wire nv_access_pkg::instr_type instr_i,
  input  wire logic [7:0]              acc_i,
  input  wire logic                    timeout_scale_option_i,
  input  wire logic                    timeout_feature_option_i,
  input  wire logic                    write_done_irq_enable_i,
  input  wire logic                    global_irq_enable_i,
  input  wire logic                    write_done_flag_clr_i,
  output logic [7:0]                   acc_o,
  output logic                         acc_valid_o,
  output logic                         busy_o,
  output logic                         write_done_flag_o,
  output logic                         irq_o,
  output logic                         write_timeout_error_o,
  output logic                         write_lock_status_o
);
  localparam int unsigned TO_MAX = 32 * MS_CYCLES;
  localparam int unsigned CNT_W  = $clog2(TO_MAX + 1);

  // the program counter must be able to reach the programming length
  if (PROG_CYCLES < 1 || MS_CYCLES < 1 || PROG_CYCLES > TO_MAX) begin : g_bad_counts
    $error("cycle counts out of range");
  end

  typedef struct packed {
    nv_access_pkg::state_type state;
    logic [6:0]               nv_address_reg;
    logic [7:0]               nv_data_reg;
    logic [7:0]               unlock_key_reg;
    logic [1:0]               key_stage;
    logic [1:0]               timeout_code;
    logic [CNT_W-1:0]         prog_cnt;
    logic [CNT_W-1:0]         to_limit;
    logic [7:0]               acc;
    logic                     acc_valid;
    logic                     done_flag;
    logic                     irq;
    logic                     to_err;
    logic                     lock;
  } state_reg_type;

  state_reg_type            cur_ff;
  state_reg_type            nxt_s;
  logic [7:0]               mem_ff [nv_access_pkg::ARRAY_BYTES];
  logic                     mem_we;
  logic [5:0]               idx;

  assign idx = cur_ff.nv_address_reg[5:0]; // see [RULE_02]

  always_comb begin
    logic [5:0] sh;
    sh = timeout_scale_option_i ? nv_access_pkg::SCALE_FINE_SH : nv_access_pkg::SCALE_COARSE_SH;
    nxt_s = cur_ff;
    mem_we = 1'b0;
    nxt_s.acc_valid = 1'b0;
    nxt_s.lock = (cur_ff.key_stage != nv_access_pkg::KEY_STAGE_OK); // see [RULE_17]
    if (!timeout_feature_option_i) nxt_s.to_err = 1'b0; // see [RULE_16]
    if (write_done_flag_clr_i) nxt_s.done_flag = 1'b0;
    unique case (cur_ff.state)
      nv_access_pkg::ST_IDLE: begin
        unique case (instr_i)
          nv_access_pkg::INSTR_ADDR_READ: begin
            nxt_s.acc = {1'b0, cur_ff.nv_address_reg}; // see [RULE_04]
            nxt_s.acc_valid = 1'b1;
          end
          nv_access_pkg::INSTR_ADDR_WRITE: nxt_s.nv_address_reg = acc_i[6:0]; // see [RULE_04]
          nv_access_pkg::INSTR_DATA_READ: begin
            nxt_s.acc = cur_ff.nv_data_reg; // see [RULE_05]
            nxt_s.acc_valid = 1'b1;
          end
          nv_access_pkg::INSTR_DATA_WRITE: nxt_s.nv_data_reg = acc_i; // see [RULE_05]
          nv_access_pkg::INSTR_ARRAY_READ: begin
            nxt_s.nv_data_reg = mem_ff[idx]; // see [RULE_06] [RULE_03] [RULE_01]
            nxt_s.acc = '0;
          end
          nv_access_pkg::INSTR_KEY_WRITE: begin
            nxt_s.unlock_key_reg = acc_i; // see [RULE_10]
            unique case (cur_ff.key_stage) // see [RULE_09]
              nv_access_pkg::KEY_STAGE_0:
                nxt_s.key_stage = (acc_i == nv_access_pkg::KEY_FIRST) ?
                                  nv_access_pkg::KEY_STAGE_1 : nv_access_pkg::KEY_STAGE_0;
              nv_access_pkg::KEY_STAGE_1:
                nxt_s.key_stage = (acc_i == nv_access_pkg::KEY_SECOND) ?
                                  nv_access_pkg::KEY_STAGE_2 : nv_access_pkg::KEY_STAGE_0;
              nv_access_pkg::KEY_STAGE_2:
                nxt_s.key_stage = (acc_i == nv_access_pkg::KEY_THIRD) ?
                                  nv_access_pkg::KEY_STAGE_OK : nv_access_pkg::KEY_STAGE_0;
              nv_access_pkg::KEY_STAGE_OK:
                nxt_s.key_stage = nv_access_pkg::KEY_STAGE_0;
            endcase
          end
          nv_access_pkg::INSTR_ARRAY_WRITE: begin
            nxt_s.timeout_code = acc_i[1:0]; // see [RULE_12]
            nxt_s.to_limit = CNT_W'(MS_CYCLES << (sh + 6'(acc_i[1:0]))); // see [RULE_13]
            if (cur_ff.key_stage == nv_access_pkg::KEY_STAGE_OK) begin
              nxt_s.state = nv_access_pkg::ST_PROG; // see [RULE_07]
              nxt_s.prog_cnt = '0;
              nxt_s.to_err = 1'b0;
            end else begin
              nxt_s.key_stage = nv_access_pkg::KEY_STAGE_0;
            end
          end
          default: ;
        endcase
        // a key sequence broken by another instruction starts over
        if (instr_i != nv_access_pkg::INSTR_KEY_WRITE && instr_i != nv_access_pkg::INSTR_NONE
            && instr_i != nv_access_pkg::INSTR_ARRAY_WRITE
            && cur_ff.key_stage != nv_access_pkg::KEY_STAGE_OK)
          nxt_s.key_stage = nv_access_pkg::KEY_STAGE_0;
      end
      nv_access_pkg::ST_PROG: begin
        nxt_s.prog_cnt = cur_ff.prog_cnt + CNT_W'(1);
        if (timeout_feature_option_i && cur_ff.prog_cnt + CNT_W'(1) >= cur_ff.to_limit
            && PROG_CYCLES > cur_ff.to_limit) begin
          nxt_s.state = nv_access_pkg::ST_IDLE;
          nxt_s.to_err = 1'b1; // see [RULE_16]
          nxt_s.key_stage = nv_access_pkg::KEY_STAGE_0; // see [RULE_18]
        end else if (cur_ff.prog_cnt + CNT_W'(1) >= CNT_W'(PROG_CYCLES)) begin
          mem_we = 1'b1; // see [RULE_07]
          nxt_s.state = nv_access_pkg::ST_IDLE;
          nxt_s.done_flag = 1'b1; // see [RULE_11]
          nxt_s.key_stage = nv_access_pkg::KEY_STAGE_0; // see [RULE_18]
        end
      end
    endcase
    nxt_s.irq = nxt_s.done_flag && write_done_irq_enable_i && global_irq_enable_i; // see [RULE_11]
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cur_ff <= '0;
      cur_ff.lock <= 1'b1; // see [RULE_17]
    end else begin
      cur_ff <= nxt_s;
    end
    if (mem_we) mem_ff[idx] <= cur_ff.nv_data_reg;
  end

  assign acc_o                 = cur_ff.acc;
  assign acc_valid_o           = cur_ff.acc_valid;
  assign busy_o                = (cur_ff.state == nv_access_pkg::ST_PROG);
  assign write_done_flag_o     = cur_ff.done_flag;
  assign irq_o                 = cur_ff.irq;
  assign write_timeout_error_o = cur_ff.to_err;
  assign write_lock_status_o   = cur_ff.lock;
endmodule : eeprom_access_unit

// File: eau_chk.sv
// port assertions for the nonvolatile byte access unit
`timescale 1ns/1ps
module eau_chk #(
  parameter int unsigned PROG_CYCLES = 20,
  parameter int unsigned MS_CYCLES   = 10
) (
  input wire logic                     sys_clk_i,
  input wire logic                     reset_i,
  input wire nv_access_pkg::instr_type instr_i,
  input wire logic [7:0]               acc_i,
  input wire logic                     timeout_scale_option_i,
  input wire logic                     timeout_feature_option_i,
  input wire logic                     write_done_irq_enable_i,
  input wire logic                     global_irq_enable_i,
  input wire logic                     write_done_flag_clr_i,
  input wire logic [7:0]               acc_o,
  input wire logic                     acc_valid_o,
  input wire logic                     busy_o,
  input wire logic                     write_done_flag_o,
  input wire logic                     irq_o,
  input wire logic                     write_timeout_error_o,
  input wire logic                     write_lock_status_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  chk_rst_lock: assert property ($fell(reset_i) |-> write_lock_status_o && !busy_o)
    else $error("lock or busy wrong after reset");
  chk_addr_rd: assert property (instr_i == nv_access_pkg::INSTR_ADDR_READ && !busy_o
    |=> acc_valid_o && !acc_o[7]) else $error("address read result wrong");
  chk_data_rd: assert property (instr_i == nv_access_pkg::INSTR_DATA_READ && !busy_o
    |=> acc_valid_o) else $error("data read not answered");
  chk_locked_wr: assert property (instr_i == nv_access_pkg::INSTR_ARRAY_WRITE && !busy_o
    && write_lock_status_o && $past(instr_i) != nv_access_pkg::INSTR_KEY_WRITE |=> !busy_o)
    else $error("write started while locked");
  chk_unlock_go: assert property (instr_i == nv_access_pkg::INSTR_ARRAY_WRITE && !busy_o
    && !$past(busy_o) && !write_lock_status_o |=> busy_o) else $error("unlocked write not started");
  // a clear in the same cycle legitimately drops the request
  chk_irq_set: assert property (write_done_flag_o && write_done_irq_enable_i
    && global_irq_enable_i && !write_done_flag_clr_i |=> irq_o) else $error("interrupt missing");
  chk_irq_gate: assert property (!global_irq_enable_i || !write_done_irq_enable_i
    |=> !irq_o) else $error("interrupt not gated");
  chk_busy_len: assert property ($rose(busy_o) |-> busy_o[*8] ##[1:300] !busy_o)
    else $error("programming length wrong");
  chk_relock: assert property ($fell(busy_o) |-> ##[0:2] write_lock_status_o)
    else $error("protection not restored");
  chk_err_off: assert property (!timeout_feature_option_i |=> !write_timeout_error_o)
    else $error("error flag set with feature off");
  cover property ($fell(busy_o) ##2 write_done_flag_o);
  cover property (write_timeout_error_o);
  cover property (irq_o);
endmodule : eau_chk

// File: core_model.sv
// processor core model that issues unit instructions
`timescale 1ns/1ps
module core_model (
  input  wire logic                sys_clk_i,
  output nv_access_pkg::instr_type instr_o,
  output logic [7:0]               acc_o
);
  initial instr_o = nv_access_pkg::INSTR_NONE;
  initial acc_o = 8'h00;
  task automatic put(input nv_access_pkg::instr_type op, input logic [7:0] v);
    @(negedge sys_clk_i);
    instr_o = op;
    acc_o = (op == nv_access_pkg::INSTR_ADDR_WRITE) ? (v & 8'h3F) : v;
  endtask : put
  task automatic issue(input nv_access_pkg::instr_type op, input logic [7:0] v);
    put(op, v);
    put(nv_access_pkg::INSTR_NONE, 8'h00);
  endtask : issue
  // three key writes on consecutive cycles
  task automatic keys(input logic [23:0] k);
    put(nv_access_pkg::INSTR_KEY_WRITE, k[23:16]);
    put(nv_access_pkg::INSTR_KEY_WRITE, k[15:8]);
    issue(nv_access_pkg::INSTR_KEY_WRITE, k[7:0]);
  endtask : keys
endmodule : core_model

// File: eeprom_access_unit_tb.sv
// self-checking bench for the nonvolatile byte access unit
`timescale 1ns/1ps
module eeprom_access_unit_tb;
  logic                     sys_clk_i = 1'b0;
  logic                     reset_i = 1'b1;
  nv_access_pkg::instr_type instr_i;
  logic [7:0]               acc_i, acc_o;
  logic                     scale = 1'b1, feat = 1'b1, wie = 1'b1, global_irq_enable = 1'b1, clr = 1'b0;
  logic                     valid, busy, done, irq, err, lock;
  int                       n_fail = 0, checked = 0, cycles = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  core_model core_model_i (.sys_clk_i(sys_clk_i), .instr_o(instr_i), .acc_o(acc_i));
  eeprom_access_unit #(.PROG_CYCLES(20), .MS_CYCLES(10)) eeprom_access_unit_i (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .instr_i(instr_i), .acc_i(acc_i),
    .timeout_scale_option_i(scale), .timeout_feature_option_i(feat),
    .write_done_irq_enable_i(wie), .global_irq_enable_i(global_irq_enable), .write_done_flag_clr_i(clr),
    .acc_o(acc_o), .acc_valid_o(valid), .busy_o(busy), .write_done_flag_o(done), .irq_o(irq),
    .write_timeout_error_o(err), .write_lock_status_o(lock));
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wait_idle();
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(negedge sys_clk_i);
    repeat (2) @(negedge sys_clk_i);
  endtask : wait_idle
  task automatic xfer(input nv_access_pkg::instr_type op, input logic [7:0] v);
    core_model_i.issue(op, v);
  endtask : xfer
  task automatic t_regs();
    xfer(nv_access_pkg::INSTR_ADDR_WRITE, 8'h25);
    xfer(nv_access_pkg::INSTR_ADDR_READ, 8'h00);
    cmp({7'h00, valid}, 8'h01);
    cmp(acc_o, 8'h25);
    xfer(nv_access_pkg::INSTR_DATA_WRITE, 8'hA5);
    xfer(nv_access_pkg::INSTR_DATA_READ, 8'h00);
    cmp(acc_o, 8'hA5);
  endtask : t_regs
  task automatic t_write();
    xfer(nv_access_pkg::INSTR_ADDR_WRITE, 8'h12);
    xfer(nv_access_pkg::INSTR_DATA_WRITE, 8'hB7);
    core_model_i.keys({nv_access_pkg::KEY_FIRST, nv_access_pkg::KEY_SECOND, nv_access_pkg::KEY_THIRD});
    xfer(nv_access_pkg::INSTR_ARRAY_WRITE, 8'h03);
    cmp({7'h00, busy}, 8'h01);
    wait_idle();
    cmp({4'h0, busy, done, irq, err, lock}, 8'h0D);
    xfer(nv_access_pkg::INSTR_DATA_WRITE, 8'h00);
    xfer(nv_access_pkg::INSTR_ARRAY_READ, 8'h00);
    xfer(nv_access_pkg::INSTR_DATA_READ, 8'h00);
    cmp(acc_o, 8'hB7);
    clr = 1'b1;
    @(negedge sys_clk_i) clr = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    cmp({6'h00, done, irq}, 8'h00);
  endtask : t_write
  task automatic t_locked();
    global_irq_enable = 1'b0;
    xfer(nv_access_pkg::INSTR_DATA_WRITE, 8'h5A);
    xfer(nv_access_pkg::INSTR_ARRAY_WRITE, 8'h03);
    cmp({7'h00, busy}, 8'h00);
    core_model_i.keys({nv_access_pkg::KEY_SECOND, nv_access_pkg::KEY_FIRST, nv_access_pkg::KEY_THIRD});
    xfer(nv_access_pkg::INSTR_ARRAY_WRITE, 8'h03);
    cmp({7'h00, busy}, 8'h00);
    xfer(nv_access_pkg::INSTR_ARRAY_READ, 8'h00);
    xfer(nv_access_pkg::INSTR_DATA_READ, 8'h00);
    cmp(acc_o, 8'hB7);
  endtask : t_locked
  task automatic t_timeout();
    global_irq_enable = 1'b1;
    core_model_i.keys({nv_access_pkg::KEY_FIRST, nv_access_pkg::KEY_SECOND, nv_access_pkg::KEY_THIRD});
    xfer(nv_access_pkg::INSTR_ARRAY_WRITE, 8'h00);
    wait_idle();
    cmp({6'h00, err, lock}, 8'h03);
    feat = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    cmp({7'h00, err}, 8'h00);
    // coarse scale stretches code 00 beyond the programming time
    feat = 1'b1;
    scale = 1'b0;
    core_model_i.keys({nv_access_pkg::KEY_FIRST, nv_access_pkg::KEY_SECOND, nv_access_pkg::KEY_THIRD});
    xfer(nv_access_pkg::INSTR_ARRAY_WRITE, 8'h00);
    wait_idle();
    cmp({6'h00, done, err}, 8'h02);
  endtask : t_timeout
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk_i);
    reset_i = 1'b0;
    cmp({3'h0, busy, done, irq, err, lock}, 8'h01);
    t_regs();
    t_write();
    t_locked();
    t_timeout();
    complete_run();
  end
endmodule : eeprom_access_unit_tb
bind eeprom_access_unit eau_chk #(.PROG_CYCLES(PROG_CYCLES), .MS_CYCLES(MS_CYCLES)) eau_chk_i (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .instr_i(instr_i), .acc_i(acc_i),
  .timeout_scale_option_i(timeout_scale_option_i), .timeout_feature_option_i(timeout_feature_option_i),
  .write_done_irq_enable_i(write_done_irq_enable_i), .global_irq_enable_i(global_irq_enable_i),
  .write_done_flag_clr_i(write_done_flag_clr_i), .acc_o(acc_o), .acc_valid_o(acc_valid_o),
  .busy_o(busy_o), .write_done_flag_o(write_done_flag_o), .irq_o(irq_o),
  .write_timeout_error_o(write_timeout_error_o), .write_lock_status_o(write_lock_status_o));
